// file: design/csg_ctrl.sv
// Clock gating controller: bus slave, gate registers, mode and faults
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module csg_ctrl (
   input wire logic CLK_SYS_I, // 200 MHz system clock
   input wire logic RST_I, // Async reset, active high
   input wire logic HSEL_I, // Slave select
   input wire logic [31:0] HADDR_I, // Byte address
   input wire logic [1:0] HTRANS_I, // Transfer type
   input wire logic HWRITE_I, // Write when high
   input wire logic [2:0] HSIZE_I, // Transfer size
   input wire logic [31:0] HWDATA_I, // Write data
   input wire logic HREADY_I, // Bus ready
   output logic [31:0] HRDATA_O, // Read data
   output logic HREADYOUT_O, // Slave ready
   output logic HRESP_O, // Response, always OKAY
   input wire logic SLEEP_REQ_I, // Core asks for sleep
   input wire logic DEEP_SLEEP_REQ_I, // Core asks for deep sleep
   input wire logic [csg_pkg::NUM_UNITS-1:0] UNIT_ACCESS_I, // Unit access
   output logic [csg_pkg::NUM_UNITS-1:0] CLK_EN_O, // Unit clock enables
   output logic [csg_pkg::NUM_UNITS-1:0] UNIT_FAULT_O, // Fault pulse
   output logic IRQ_O // Interrupt level
);
   import csg_pkg::*;

   // ------------------------------------------------------------
   // Mode request synchronisers
   // ------------------------------------------------------------
   logic [2:0] slp_sync_q;
   logic [2:0] dsl_sync_q;
   logic slp_lvl_q;
   logic dsl_lvl_q;

   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         slp_sync_q <= '0;
         dsl_sync_q <= '0;
      end else begin
         slp_sync_q <= {slp_sync_q[1:0], SLEEP_REQ_I};
         dsl_sync_q <= {dsl_sync_q[1:0], DEEP_SLEEP_REQ_I};
      end
   end

   // Level moves only once the last two stages agree
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         slp_lvl_q <= 1'b0;
         dsl_lvl_q <= 1'b0;
      end else begin
         if (slp_sync_q[1] == slp_sync_q[2]) begin
            slp_lvl_q <= slp_sync_q[2];
         end
         if (dsl_sync_q[1] == dsl_sync_q[2]) begin
            dsl_lvl_q <= dsl_sync_q[2];
         end
      end
   end

   // ------------------------------------------------------------
   // Power mode state
   // ------------------------------------------------------------
   csg_mode_e mode_q;
   csg_mode_e mode_d;

   // Deep sleep outranks sleep when both are asked for
   always_comb begin
      mode_d = mode_q;
      case (mode_q)
         MODE_RUN: begin
            if (dsl_lvl_q) begin
               mode_d = MODE_DEEP;
            end else if (slp_lvl_q) begin
               mode_d = MODE_SLEEP;
            end
         end
         MODE_SLEEP: begin
            if (dsl_lvl_q) begin
               mode_d = MODE_DEEP;
            end else if (!slp_lvl_q) begin
               mode_d = MODE_RUN;
            end
         end
         MODE_DEEP: begin
            if (!dsl_lvl_q) begin
               mode_d = slp_lvl_q ? MODE_SLEEP : MODE_RUN;
            end
         end
         default: mode_d = MODE_RUN;
      endcase
   end

   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         mode_q <= MODE_RUN;
      end else begin
         mode_q <= mode_d; // RQ6
      end
   end

   // ------------------------------------------------------------
   // Bus address phase capture
   // ------------------------------------------------------------
   logic addr_ok;
   logic xfer_valid;
   logic wr_pend_q;
   logic [OFS_W-1:0] wr_ofs_q;

   assign addr_ok = (HADDR_I[31:OFS_W] == CSG_BASE_ADDR[31:OFS_W]);
   assign xfer_valid = HSEL_I && HREADY_I &&
      ((HTRANS_I == HTRANS_NONSEQ) || (HTRANS_I == HTRANS_SEQ));

   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         wr_pend_q <= 1'b0;
         wr_ofs_q <= '0;
      end else begin
         wr_pend_q <= xfer_valid && HWRITE_I && addr_ok;
         wr_ofs_q <= HADDR_I[OFS_W-1:0];
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [31:0] run_gate_q;
   logic [31:0] sleep_gate_q;
   logic [31:0] deep_gate_q;
   logic [31:0] run_cfg_q;
   logic [NUM_UNITS-1:0] irq_stat_q;
   logic [NUM_UNITS-1:0] irq_mask_q;
   logic [NUM_UNITS-1:0] fault_evt;
   logic [NUM_UNITS-1:0] stat_clr;

   // Reserved bits never store, so they read zero
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         run_gate_q <= GATE_RESET; // RQ4
         sleep_gate_q <= GATE_RESET; // RQ4
         deep_gate_q <= GATE_RESET; // RQ4
      end else if (wr_pend_q) begin
         if (wr_ofs_q == OFS_RUN_GATE) begin
            run_gate_q <= HWDATA_I & GATE_MASK; // RQ11
         end else if (wr_ofs_q == OFS_SLEEP_GATE) begin
            sleep_gate_q <= HWDATA_I & GATE_MASK; // RQ11
         end else if (wr_ofs_q == OFS_DEEP_GATE) begin
            deep_gate_q <= HWDATA_I & GATE_MASK; // RQ8 RQ9 RQ10 RQ11
         end
      end
   end

   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         run_cfg_q <= CFG_RESET;
      end else if (wr_pend_q && (wr_ofs_q == OFS_RUN_CFG)) begin
         run_cfg_q <= HWDATA_I & CFG_MASK;
      end
   end

   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         irq_mask_q <= IRQ_RESET;
      end else if (wr_pend_q && (wr_ofs_q == OFS_IRQ_MASK)) begin
         irq_mask_q <= HWDATA_I[NUM_UNITS-1:0];
      end
   end

   assign stat_clr = (wr_pend_q && (wr_ofs_q == OFS_IRQ_STAT)) ?
      HWDATA_I[NUM_UNITS-1:0] : '0;

   // A fault in the clearing cycle stays set
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         irq_stat_q <= IRQ_RESET;
      end else begin
         irq_stat_q <= (irq_stat_q & ~stat_clr) | fault_evt;
      end
   end

   // ------------------------------------------------------------
   // Gate selection
   // ------------------------------------------------------------
   csg_gate_if gif ();

   assign gif.run_set = run_gate_q;
   assign gif.sleep_set = sleep_gate_q;
   assign gif.deep_set = deep_gate_q;
   assign gif.auto_sel = run_cfg_q[AUTO_GATING_BIT]; // RQ7
   assign gif.mode = mode_q;

   csg_gate_sel u_sel (
      .clk_i(CLK_SYS_I),
      .rst_i(RST_I),
      .gif(gif)
   );

   assign CLK_EN_O = gif.en; // RQ1 RQ2

   // ------------------------------------------------------------
   // Unit access faults
   // ------------------------------------------------------------
   // Nothing wakes a unit on access: software must open its gate first
   assign fault_evt = UNIT_ACCESS_I & ~gif.en; // RQ3 RQ5

   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         UNIT_FAULT_O <= '0;
      end else begin
         UNIT_FAULT_O <= fault_evt; // RQ3
      end
   end

   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         IRQ_O <= 1'b0;
      end else begin
         IRQ_O <= |(((irq_stat_q & ~stat_clr) | fault_evt) & irq_mask_q);
      end
   end

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   logic [31:0] rd_mux;
   logic [OFS_W-1:0] rd_ofs;

   assign rd_ofs = HADDR_I[OFS_W-1:0];

   // Unmapped or outside the block: zero
   always_comb begin
      rd_mux = RDATA_ZERO;
      if (!addr_ok) begin
         rd_mux = RDATA_ZERO;
      end else if (rd_ofs == OFS_RUN_GATE) begin
         rd_mux = run_gate_q;
      end else if (rd_ofs == OFS_SLEEP_GATE) begin
         rd_mux = sleep_gate_q;
      end else if (rd_ofs == OFS_DEEP_GATE) begin
         rd_mux = deep_gate_q; // RQ8
      end else if (rd_ofs == OFS_RUN_CFG) begin
         rd_mux = run_cfg_q;
      end else if (rd_ofs == OFS_IRQ_STAT) begin
         rd_mux = {{(32-NUM_UNITS){1'b0}}, irq_stat_q};
      end else if (rd_ofs == OFS_IRQ_MASK) begin
         rd_mux = {{(32-NUM_UNITS){1'b0}}, irq_mask_q};
      end
   end

   // Zero-wait slave: data is latched at the address phase edge
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         HRDATA_O <= RDATA_ZERO;
      end else if (xfer_valid && !HWRITE_I) begin
         HRDATA_O <= rd_mux;
      end
   end

   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         HREADYOUT_O <= 1'b1;
         HRESP_O <= HRESP_OKAY;
      end else begin
         HREADYOUT_O <= 1'b1;
         HRESP_O <= HRESP_OKAY;
      end
   end

endmodule
`default_nettype wire

// file: design/csg_pkg.sv
// Constants and types for the deep-sleep clock gating controller
// Function
// RQ1: A set gate bit supplies the clock enable to its peripheral unit.
// RQ2: A cleared gate bit drops the unit's clock enable, keeping it disabled.
// RQ3: Accesses to an unclocked unit are answered with a bus fault.
// RQ4: All gate bits reset to zero; every gated unit starts unclocked.
// RQ5: Software enables each needed unit before use; nothing enables itself.
// RQ6: Run, sleep and deep-sleep gate sets apply in their own modes.
// RQ7: Sleep and deep-sleep sets apply only while auto gating is selected.
// RQ8: Deep-sleep gate register is 32 bits at offset 0x124 from base.
// RQ9: Bit 24 gates the analog comparator.
// RQ10: Bits 18..16 counters c,b,a; bit 4 sync serial; bits 1,0 serial b,a.
// RQ11: Unassigned bits are read-only zero; software preserves them.
package csg_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [31:0] CSG_BASE_ADDR = 32'h400fe000;
   localparam int unsigned OFS_W = 12;
   localparam logic [11:0] OFS_RUN_CFG = 12'h060;
   localparam logic [11:0] OFS_RUN_GATE = 12'h104;
   localparam logic [11:0] OFS_SLEEP_GATE = 12'h114;
   localparam logic [11:0] OFS_DEEP_GATE = 12'h124;
   localparam logic [11:0] OFS_IRQ_STAT = 12'h200;
   localparam logic [11:0] OFS_IRQ_MASK = 12'h204;

   // ------------------------------------------------------------
   // Field layout
   // ------------------------------------------------------------
   localparam int unsigned NUM_UNITS = 7;
   // Unit order: serial a, serial b, sync serial, counter a/b/c, comparator
   localparam int unsigned GATE_POS [0:NUM_UNITS-1] =
      '{0, 1, 4, 16, 17, 18, 24};
   localparam logic [31:0] GATE_MASK = 32'h01070013;
   localparam logic [31:0] GATE_RESET = 32'h00000000;
   localparam int unsigned AUTO_GATING_BIT = 0;
   localparam logic [31:0] CFG_MASK = 32'h00000001;
   localparam logic [31:0] CFG_RESET = 32'h00000000;
   localparam logic [31:0] IRQ_FIELD_MASK = 32'h0000007f;
   localparam logic [NUM_UNITS-1:0] IRQ_RESET = 7'h00;

   // ------------------------------------------------------------
   // Bus encodings
   // ------------------------------------------------------------
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;
   localparam logic HRESP_OKAY = 1'b0;
   localparam logic [31:0] RDATA_ZERO = 32'h00000000;

   typedef enum logic [2:0] {
      MODE_RUN = 3'b001,
      MODE_SLEEP = 3'b010,
      MODE_DEEP = 3'b100
   } csg_mode_e;

endpackage

// file: design/csg_gate_if.sv
// Gate sets and power mode carried from the controller to the selector
`timescale 1ns/10ps
`default_nettype none
interface csg_gate_if;
   import csg_pkg::*;
   logic [31:0] run_set;
   logic [31:0] sleep_set;
   logic [31:0] deep_set;
   logic auto_sel;
   csg_mode_e mode;
   logic [NUM_UNITS-1:0] en;

   modport ctrl (output run_set, sleep_set, deep_set, auto_sel, mode,
                 input en);
   modport sel (input run_set, sleep_set, deep_set, auto_sel, mode,
                output en);
endinterface
`default_nettype wire

// file: design/csg_gate_sel.sv
// Picks the active gate set for the power mode and registers unit enables
`timescale 1ns/10ps
`default_nettype none
module csg_gate_sel (
   input wire logic clk_i, // System clock
   input wire logic rst_i, // Async reset, active high
   csg_gate_if.sel gif     // Gate sets in, enables out
);
   import csg_pkg::*;

   logic [31:0] active_set;
   logic [NUM_UNITS-1:0] en_d;
   logic [NUM_UNITS-1:0] en_q;

   // Without auto gating the run set holds in every mode
   always_comb begin
      active_set = gif.run_set; // RQ7
      if (gif.auto_sel) begin
         case (gif.mode)
            MODE_SLEEP: active_set = gif.sleep_set; // RQ6
            MODE_DEEP: active_set = gif.deep_set; // RQ6
            default: active_set = gif.run_set; // RQ6
         endcase
      end
   end

   genvar u;
   generate
      for (u = 0; u < NUM_UNITS; u = u + 1) begin : g_unit
         assign en_d[u] = active_set[GATE_POS[u]]; // RQ1 RQ2
      end
   endgenerate

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         en_q <= '0; // RQ4
      end else begin
         en_q <= en_d;
      end
   end

   assign gif.en = en_q;
endmodule
`default_nettype wire

// file: verification/csg_ctrl_assertions.sv
// Port-level checker for the clock gating controller
`timescale 1ns/10ps
`default_nettype none
module csg_ctrl_assertions (
   input wire logic CLK_SYS_I, // System clock
   input wire logic RST_I, // Async reset
   input wire logic HSEL_I, // Select
   input wire logic [31:0] HADDR_I, // Address
   input wire logic [1:0] HTRANS_I, // Transfer type
   input wire logic HWRITE_I, // Write
   input wire logic HREADY_I, // Bus ready
   input wire logic [31:0] HRDATA_O, // Read data
   input wire logic HREADYOUT_O, // Slave ready
   input wire logic HRESP_O, // Response
   input wire logic SLEEP_REQ_I, // Sleep request
   input wire logic DEEP_SLEEP_REQ_I, // Deep sleep request
   input wire logic [csg_pkg::NUM_UNITS-1:0] UNIT_ACCESS_I, // Accesses
   input wire logic [csg_pkg::NUM_UNITS-1:0] CLK_EN_O, // Enables
   input wire logic [csg_pkg::NUM_UNITS-1:0] UNIT_FAULT_O, // Faults
   input wire logic IRQ_O // Interrupt
);
   import csg_pkg::*;
   logic acc_a;
   logic wr_a;
   logic [3:0] pin_age_q;
   assign acc_a = HSEL_I && HREADY_I && HTRANS_I[1];
   assign wr_a = acc_a && HWRITE_I;
   // Mode pins pass a synchroniser, so allow a settling span
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         pin_age_q <= 4'h0;
      end else if (!$stable({SLEEP_REQ_I, DEEP_SLEEP_REQ_I})) begin
         pin_age_q <= 4'h0;
      end else if (pin_age_q != 4'hf) begin
         pin_age_q <= pin_age_q + 4'h1;
      end
   end
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (RST_I);
   sequence rd_deep_s;
      acc_a && !HWRITE_I && HADDR_I == CSG_BASE_ADDR + {20'h0, OFS_DEEP_GATE};
   endsequence
   AST_FAULT_EXACT:
      assert property (##1 UNIT_FAULT_O == $past(UNIT_ACCESS_I & ~CLK_EN_O))
      else $error("Fault pulse mismatch");
   AST_NO_FAULT_CLOCKED:
      assert property ((UNIT_ACCESS_I & CLK_EN_O) != '0 |=>
         (UNIT_FAULT_O & $past(UNIT_ACCESS_I & CLK_EN_O)) == '0)
      else $error("Fault on clocked unit");
   AST_BUS_OKAY:
      assert property (HREADYOUT_O && HRESP_O == HRESP_OKAY)
      else $error("Bus not ready or not okay");
   AST_RSVD_ZERO:
      assert property (rd_deep_s |=> (HRDATA_O & ~GATE_MASK) == '0)
      else $error("Reserved bits read nonzero");
   AST_RDATA_HOLD:
      assert property (!(acc_a && !HWRITE_I) |=> $stable(HRDATA_O))
      else $error("Read data moved without read");
   AST_EN_CAUSE:
      assert property ($changed(CLK_EN_O) |-> pin_age_q < 4'hc ||
         $past(wr_a, 2) || $past(wr_a, 3) || $past(wr_a, 4))
      else $error("Enables moved without cause");
   AST_RESET_CLEAR:
      assert property (disable iff (1'b0) $fell(RST_I) |->
         CLK_EN_O == '0 && !IRQ_O && UNIT_FAULT_O == '0)
      else $error("Outputs not clear after reset");
   AST_IRQ_CAUSE:
      assert property ($rose(IRQ_O) |-> (|UNIT_FAULT_O) ||
         $past(|UNIT_FAULT_O) || $past(wr_a, 2) || $past(wr_a, 3))
      else $error("Interrupt rose without cause");
endmodule
bind csg_ctrl csg_ctrl_assertions i_csg_ctrl_assertions (.CLK_SYS_I,
   .RST_I, .HSEL_I, .HADDR_I, .HTRANS_I, .HWRITE_I, .HREADY_I,
   .HRDATA_O, .HREADYOUT_O, .HRESP_O, .SLEEP_REQ_I, .DEEP_SLEEP_REQ_I,
   .UNIT_ACCESS_I, .CLK_EN_O, .UNIT_FAULT_O, .IRQ_O);
`default_nettype wire

// file: verification/csg_ctrl_tb.sv
// Self-checking bench for the clock gating controller
`timescale 1ns/10ps
`default_nettype none
module csg_ctrl_tb;
   import csg_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = '0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = '0;
   logic slp = 1'b0;
   logic dslp = 1'b0;
   logic [6:0] acc = '0;
   logic [31:0] rdata;
   logic rdy;
   logic [6:0] en;
   logic [6:0] flt;
   logic irq;
   logic resp;
   logic [31:0] rd;
   int errors = 0;
   int checked = 0;
   always #2.5 clk = ~clk;
   csg_ctrl i_csg_ctrl (.CLK_SYS_I(clk), .RST_I(rst), .HSEL_I(hsel),
      .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
      .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(rdy),
      .HRDATA_O(rdata), .HREADYOUT_O(rdy), .HRESP_O(resp),
      .SLEEP_REQ_I(slp), .DEEP_SLEEP_REQ_I(dslp), .UNIT_ACCESS_I(acc),
      .CLK_EN_O(en), .UNIT_FAULT_O(flt), .IRQ_O(irq));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] e, g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] o,
         input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= CSG_BASE_ADDR + {20'h0, o};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      rd = rdata;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      bus(1'b0, OFS_DEEP_GATE, '0);
      chk("deep gate", 32'h0, rd);
      bus(1'b0, OFS_RUN_CFG, '0);
      chk("run cfg", 32'h0, rd);
      chk("enables", 32'h0, {25'h0, en});
   endtask
   task automatic t_map;
      bus(1'b1, OFS_DEEP_GATE, 32'hffffffff);
      bus(1'b0, OFS_DEEP_GATE, '0);
      chk("deep gate", 32'h01070013, rd);
      bus(1'b1, 12'h300, 32'hffffffff);
      bus(1'b0, 12'h300, '0);
      chk("unmapped", 32'h0, rd);
      chk("resp", {31'h0, HRESP_OKAY}, {31'h0, resp});
   endtask
   task automatic t_modes;
      int pos [7] = '{0, 1, 4, 16, 17, 18, 24};
      bus(1'b1, OFS_RUN_GATE, 32'h1);
      bus(1'b1, OFS_RUN_CFG, 32'h1);
      dslp <= 1'b1;
      cyc(10);
      for (int i = 0; i < 7; i++) begin
         bus(1'b1, OFS_DEEP_GATE, 32'h1 << pos[i]);
         cyc(4);
         chk("deep enables", 32'h1 << i, {25'h0, en});
      end
      bus(1'b1, OFS_RUN_CFG, 32'h0);
      cyc(4);
      chk("no auto", 32'h1, {25'h0, en});
      bus(1'b1, OFS_RUN_CFG, 32'h1);
      dslp <= 1'b0;
      slp <= 1'b1;
      cyc(10);
      chk("sleep enables", 32'h0, {25'h0, en});
      bus(1'b1, OFS_SLEEP_GATE, 32'h10);
      cyc(4);
      chk("sleep set", 32'h4, {25'h0, en});
      slp <= 1'b0;
      cyc(10);
      chk("run enables", 32'h1, {25'h0, en});
   endtask
   task automatic t_fault;
      bus(1'b1, OFS_IRQ_MASK, 32'h4);
      acc <= 7'h07;
      @(posedge clk);
      acc <= 7'h00;
      @(posedge clk);
      chk("faults", 32'h6, {25'h0, flt});
      cyc(2);
      chk("irq", 32'h1, {31'h0, irq});
      bus(1'b0, OFS_IRQ_STAT, '0);
      chk("status", 32'h6, rd);
      bus(1'b1, OFS_IRQ_STAT, 32'h4);
      cyc(2);
      chk("masked irq", 32'h0, {31'h0, irq});
      bus(1'b0, OFS_IRQ_STAT, '0);
      chk("status", 32'h2, rd);
   endtask
   // Reset again with gates, status and mask all loaded
   task automatic t_rst_mid;
      @(posedge clk);
      rst <= 1'b1;
      cyc(3);
      chk("enables in reset", 32'h0, {25'h0, en});
      rst <= 1'b0;
      bus(1'b0, OFS_RUN_GATE, '0);
      chk("run gate", 32'h0, rd);
      chk("enables", 32'h0, {25'h0, en});
      chk("irq", 32'h0, {31'h0, irq});
      bus(1'b0, OFS_IRQ_STAT, '0);
      chk("status", 32'h0, rd);
   endtask
   task automatic print_verdict;
      $display("Checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_map();
      t_modes();
      t_fault();
      t_rst_mid();
      print_verdict();
   end
   initial begin
      #200000;
      errors++;
      print_verdict();
   end
endmodule
`default_nettype wire
